// ==== hw/ldp_core.sv ====
// Datapath for add, and, bit set/clear and bit test-skip
`timescale 1ns/1ns
`default_nettype none
`include "ldp_params.svh"
module ldp_core import ldp_pkg::*; (
	input wire logic mclk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [13:0] instr,
	input wire logic [7:0] port_pins,
	output logic [7:0] accum,
	output logic carry_flag,
	output logic half_carry_flag,
	output logic zero_flag,
	output logic skip_next,
	output logic [7:0] port_latch
);
	logic [7:0] acc_ff, nxt_acc;
	logic carry_ff, nxt_carry;
	logic half_carry_ff, nxt_half_carry;
	logic zero_ff, nxt_zero;
	logic skip_ff, nxt_skip;
	ldp_op_t op;
	logic exec;
	logic dest;
	logic [2:0] bidx;
	logic [6:0] fadr;
	logic [7:0] lit;
	logic [7:0] rd_data;
	logic wr_en;
	logic [7:0] wr_data;
	logic [7:0] bit_mask;
	ldp_sum_t sum;

	function automatic ldp_op_t ldp_decode(input logic [13:0] ins);
		ldp_op_t res;
		res = LDP_OP_NONE;
		if (ins[13:8] == `LDP_OPC_ADDR) begin
			res = LDP_OP_ADDR;
		end else if (ins[13:8] == `LDP_OPC_ANDR) begin
			res = LDP_OP_ANDR;
		end else if (ins[13:8] == `LDP_OPC_ANDI) begin
			res = LDP_OP_ANDI;
		end else if (ins[13:9] == `LDP_OPC_ADDI) begin
			res = LDP_OP_ADDI;
		end else if (ins[13:12] == `LDP_GRP_BIT) begin
			case (ins[11:10])
				`LDP_BIT_CLR: res = LDP_OP_BCLR;
				`LDP_BIT_SET: res = LDP_OP_BSET;
				`LDP_BIT_TST0: res = LDP_OP_TST0;
				default: res = LDP_OP_TST1;
			endcase
		end
		return res;
	endfunction : ldp_decode

	// Carry from bits 7 and 3
	function automatic ldp_sum_t ldp_add(input logic [7:0] a, input logic [7:0] b);
		ldp_sum_t r;
		logic [4:0] lo;
		logic [8:0] full;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		full = {1'b0, a} + {1'b0, b};
		r.carry = full[8];
		r.half_carry = lo[4];
		r.sum = full[7:0];
		return r;
	endfunction : ldp_add

	assign op = ldp_decode(instr);
	assign exec = instr_valid && !skip_ff;
	assign dest = instr[`LDP_DEST_POS];
	assign bidx = instr[`LDP_BIDX_LO +: 3];
	assign fadr = instr[6:0];
	assign lit = instr[7:0];
	assign bit_mask = 8'h01 << bidx;
	assign sum = ldp_add(acc_ff, (op == LDP_OP_ADDI) ? lit : rd_data);

	ldp_regfile u_regfile (
		.mclk(mclk),
		.rst(rst),
		.rd_adr(fadr),
		.rd_data(rd_data),
		.wr_en(wr_en),
		.wr_adr(fadr),
		.wr_data(wr_data),
		.port_pins(port_pins),
		.port_latch(port_latch)
	);

	always_comb begin
		nxt_acc = acc_ff;
		nxt_carry = carry_ff;
		nxt_half_carry = half_carry_ff;
		nxt_zero = zero_ff;
		nxt_skip = skip_ff;
		wr_en = 1'b0;
		wr_data = rd_data;
		if (instr_valid && skip_ff) begin
			nxt_skip = 1'b0;
		end else if (exec) begin
			case (op)
				LDP_OP_ADDI: begin
					nxt_acc = sum.sum;
					nxt_carry = sum.carry;
					nxt_half_carry = sum.half_carry;
					nxt_zero = (sum.sum == 8'h00);
				end
				LDP_OP_ADDR: begin
					nxt_carry = sum.carry;
					nxt_half_carry = sum.half_carry;
					nxt_zero = (sum.sum == 8'h00);
					if (dest) begin
						wr_en = 1'b1;
						wr_data = sum.sum;
					end else begin
						nxt_acc = sum.sum;
					end
				end
				LDP_OP_ANDI: begin
					nxt_acc = acc_ff & lit;
					nxt_zero = ((acc_ff & lit) == 8'h00);
				end
				LDP_OP_ANDR: begin
					nxt_zero = ((acc_ff & rd_data) == 8'h00);
					if (dest) begin
						wr_en = 1'b1;
						wr_data = acc_ff & rd_data;
					end else begin
						nxt_acc = acc_ff & rd_data;
					end
				end
				LDP_OP_BCLR: begin
					wr_en = 1'b1;
					wr_data = rd_data & ~bit_mask;
				end
				LDP_OP_BSET: begin
					wr_en = 1'b1;
					wr_data = rd_data | bit_mask;
				end
				LDP_OP_TST0: nxt_skip = !rd_data[bidx];
				LDP_OP_TST1: nxt_skip = rd_data[bidx];
				default: nxt_skip = 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			acc_ff <= `LDP_ACC_RST;
			carry_ff <= 1'b0;
			half_carry_ff <= 1'b0;
			zero_ff <= 1'b0;
			skip_ff <= 1'b0;
		end else begin
			acc_ff <= nxt_acc;
			carry_ff <= nxt_carry;
			half_carry_ff <= nxt_half_carry;
			zero_ff <= nxt_zero;
			skip_ff <= nxt_skip;
		end
	end

	assign accum = acc_ff;
	assign carry_flag = carry_ff;
	assign half_carry_flag = half_carry_ff;
	assign zero_flag = zero_ff;
	assign skip_next = skip_ff;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_addi_sum: assert property (exec && op == LDP_OP_ADDI
		|=> acc_ff == 8'($past(acc_ff) + $past(lit))
		&& carry_ff == ((9'($past(acc_ff)) + 9'($past(lit))) > 9'h0FF))
		else $error("add immediate result or carry wrong");
	a_addr_dest: assert property (exec && op == LDP_OP_ADDR && !dest
		|=> acc_ff == 8'($past(acc_ff) + $past(rd_data)))
		else $error("add register to accumulator wrong");
	a_andi_flags: assert property (exec && op == LDP_OP_ANDI
		|=> acc_ff == ($past(acc_ff) & $past(lit))
		&& $stable(carry_ff) && $stable(half_carry_ff))
		else $error("and immediate wrong or flags touched");
	a_andr_keep: assert property (exec && op == LDP_OP_ANDR && dest
		|-> wr_en && wr_data == (acc_ff & rd_data) ##1 $stable(acc_ff) && $stable(carry_ff))
		else $error("and register to file wrong");
	a_bclr_flags: assert property (exec && op == LDP_OP_BCLR
		|-> wr_en && !wr_data[bidx]
		##1 $stable(zero_ff) && $stable(carry_ff) && $stable(half_carry_ff))
		else $error("bit clear wrong or flags touched");
	a_bset_bits: assert property (exec && op == LDP_OP_BSET
		|-> wr_en && wr_data[bidx] && ((wr_data ^ rd_data) & ~bit_mask) == 8'h00)
		else $error("bit set disturbed other bits");
	a_skip_one: assert property (exec && op == LDP_OP_TST1 |=> skip_ff == $past(rd_data[bidx]))
		else $error("skip if one decision wrong");
	a_skip_zero: assert property (exec && op == LDP_OP_TST0 |=> skip_ff == !$past(rd_data[bidx]))
		else $error("skip if zero decision wrong");
	a_skip_nop: assert property (skip_ff && instr_valid |-> !wr_en ##1 !skip_ff && $stable(acc_ff))
		else $error("skipped instruction had an effect");
	a_tst_decode: assert property (instr[13:10] == 4'h6 |-> op == LDP_OP_TST0)
		else $error("bit test decode wrong");
	a_port_pins: assert property (fadr == `LDP_PORT_ADDR |-> rd_data == port_pins)
		else $error("port read not from pins");
	a_zero_flag: assert property (exec && op == LDP_OP_ADDI |=> zero_ff == (acc_ff == 8'h00))
		else $error("zero flag wrong");
	a_one_cycle: assert property (exec && op != LDP_OP_TST0 && op != LDP_OP_TST1 |=> !skip_ff)
		else $error("non-skip instruction stalled");

	c_skip_taken: cover property (exec && op == LDP_OP_TST1 && rd_data[bidx] ##1 skip_ff && instr_valid);
	c_add_carry: cover property (exec && op == LDP_OP_ADDI && sum.carry);
	c_write_back: cover property (exec && op == LDP_OP_ADDR && dest);
	c_port_bset: cover property (exec && op == LDP_OP_BSET && fadr == `LDP_PORT_ADDR);
endmodule : ldp_core
`default_nettype wire

// ==== pkg/ldp_params.svh ====
// Constants for the literal and bit operation datapath
// How it works
// - Add immediate adds 8-bit literal to accumulator; updates carry, half carry, zero.
// - Add register sums accumulator and register; destination bit picks accumulator or register.
// - And immediate ANDs literal into accumulator; only zero flag changes.
// - And register ANDs accumulator with register to chosen destination; only zero flag changes.
// - Bit clear zeroes one register bit, keeps other bits and all flags.
// - Bit set forces one register bit high, keeps other bits and all flags.
// - Test skip if one discards the next instruction when the tested bit is one.
// - Test skip if zero discards the next instruction when the tested bit is zero.
// - Bit tests decode from top bits 01 then 10 or 11, index, address.
// - Reading a port register for read-modify-write returns pin levels, not the latch.
`ifndef LDP_PARAMS_SVH
`define LDP_PARAMS_SVH

`define LDP_ADDR_W 7
`define LDP_NUM_REGS 128
`define LDP_PORT_ADDR 7'h06
`define LDP_ACC_RST 8'h00
`define LDP_REG_RST 8'h00
`define LDP_OPC_HI 13
`define LDP_OPC_ADDR 6'h07
`define LDP_OPC_ANDR 6'h05
`define LDP_OPC_ANDI 6'h39
`define LDP_OPC_ADDI 5'h1F
`define LDP_GRP_BIT 2'h1
`define LDP_BIT_CLR 2'h0
`define LDP_BIT_SET 2'h1
`define LDP_BIT_TST0 2'h2
`define LDP_BIT_TST1 2'h3
`define LDP_DEST_POS 7
`define LDP_BIDX_LO 7

`endif

// ==== pkg/ldp_pkg.sv ====
// Types for the literal and bit operation datapath
`default_nettype none
package ldp_pkg;
	typedef enum logic [3:0] {
		LDP_OP_NONE,
		LDP_OP_ADDI,
		LDP_OP_ADDR,
		LDP_OP_ANDI,
		LDP_OP_ANDR,
		LDP_OP_BCLR,
		LDP_OP_BSET,
		LDP_OP_TST0,
		LDP_OP_TST1
	} ldp_op_t;

	typedef struct packed {
		logic carry;
		logic half_carry;
		logic [7:0] sum;
	} ldp_sum_t;
endpackage : ldp_pkg
`default_nettype wire

// ==== hw/ldp_regfile.sv ====
// File register storage with pin-aware port register read
`timescale 1ns/1ns
`default_nettype none
`include "ldp_params.svh"
module ldp_regfile (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [6:0] rd_adr,
	output logic [7:0] rd_data,
	input wire logic wr_en,
	input wire logic [6:0] wr_adr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] port_pins,
	output logic [7:0] port_latch
);
	logic [7:0] mem_ff [`LDP_NUM_REGS];
	logic [7:0] nxt_mem [`LDP_NUM_REGS];

	always_comb begin
		if (rd_adr == `LDP_PORT_ADDR) begin
			rd_data = port_pins;
		end else begin
			rd_data = mem_ff[rd_adr];
		end
	end

	always_comb begin
		nxt_mem = mem_ff;
		if (wr_en) begin
			nxt_mem[wr_adr] = wr_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			mem_ff <= '{default: `LDP_REG_RST};
		end else begin
			mem_ff <= nxt_mem;
		end
	end

	assign port_latch = mem_ff[`LDP_PORT_ADDR];
endmodule : ldp_regfile
`default_nettype wire

// ==== verif/ldp_core_tb_top.sv ====
// Self-checking testbench for the literal and bit operation datapath
`timescale 1ns/1ns
`default_nettype none
module ldp_core_tb_top import ldp_pkg::*;;
	typedef struct packed {
		logic [13:0] instr;
		logic [7:0] acc;
		logic [3:0] flg;
	} ldp_row_t;
	logic mclk;
	logic rst;
	logic instr_valid;
	logic [13:0] instr;
	logic [7:0] port_pins;
	logic [7:0] accum;
	logic carry_flag;
	logic half_carry_flag;
	logic zero_flag;
	logic skip_next;
	logic [7:0] port_latch;
	int err_total;
	int num_checks;
	// Rows: instruction, accumulator, {carry, half carry, zero, skip}
	ldp_row_t rows [22] = '{
		'{14'h3E0F, 8'h0F, 4'h0}, '{14'h3E01, 8'h10, 4'h4}, '{14'h3EF0, 8'h00, 4'hA},
		'{14'h3FFF, 8'hFF, 4'h0}, '{14'h07A0, 8'hFF, 4'h0}, '{14'h0720, 8'hFE, 4'hC},
		'{14'h3901, 8'h00, 4'hE}, '{14'h3E3C, 8'h3C, 4'h0}, '{14'h0520, 8'h3C, 4'h0},
		'{14'h05A0, 8'h3C, 4'h0}, '{14'h1120, 8'h3C, 4'h0}, '{14'h17A0, 8'h3C, 4'h0},
		'{14'h3900, 8'h00, 4'h2}, '{14'h0720, 8'hB8, 4'h0}, '{14'h1FA0, 8'hB8, 4'h1},
		'{14'h3E01, 8'hB8, 4'h0}, '{14'h1BA0, 8'hB8, 4'h0}, '{14'h3E01, 8'hB9, 4'h0},
		'{14'h1920, 8'hB9, 4'h1}, '{14'h3900, 8'hB9, 4'h0}, '{14'h1C20, 8'hB9, 4'h0},
		'{14'h3400, 8'hB9, 4'h0}
	};

	ldp_core dut (
		.mclk(mclk),
		.rst(rst),
		.instr_valid(instr_valid),
		.instr(instr),
		.port_pins(port_pins),
		.accum(accum),
		.carry_flag(carry_flag),
		.half_carry_flag(half_carry_flag),
		.zero_flag(zero_flag),
		.skip_next(skip_next),
		.port_latch(port_latch)
	);

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task exec(input logic [13:0] i);
		instr = i;
		instr_valid = 1'b1;
		@(negedge mclk);
	endtask : exec

	task chk_state(input logic [7:0] acc, input logic [3:0] flg);
		chk("accum", accum, acc);
		chk("flags", {4'h0, carry_flag, half_carry_flag, zero_flag, skip_next}, {4'h0, flg});
	endtask : chk_state

	task results;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	initial begin
		#(20 * 500);
		err_total++;
		results();
	end

	initial begin
		err_total = 0;
		num_checks = 0;
		rst = 1'b1;
		instr_valid = 1'b0;
		instr = 14'h0000;
		port_pins = 8'hA5;
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		// Reset values
		chk_state(8'h00, 4'h0);
		chk("latch", port_latch, 8'h00);
		foreach (rows[n]) begin
			exec(rows[n].instr);
			chk_state(rows[n].acc, rows[n].flg);
		end
		port_pins = 8'h5A;
		exec(14'h1406);
		chk("latch", port_latch, 8'h5B);
		exec(14'h3900);
		exec(14'h0706);
		chk("accum", accum, 8'h5A);
		exec(14'h1C86);
		instr_valid = 1'b0;
		repeat (2) @(negedge mclk);
		chk("skip", {7'h00, skip_next}, 8'h01);
		exec(14'h3E01);
		chk_state(8'h5A, 4'h0);
		exec(14'h1C86);
		instr_valid = 1'b0;
		rst = 1'b1;
		@(negedge mclk);
		rst = 1'b0;
		// Reset in mid-run
		chk_state(8'h00, 4'h0);
		chk("latch", port_latch, 8'h00);
		@(negedge mclk);
		chk_state(8'h00, 4'h0);
		// First instruction after release
		exec(14'h3E01);
		chk_state(8'h01, 4'h0);
		exec(14'h0720);
		chk_state(8'h01, 4'h0);
		instr_valid = 1'b0;
		results();
	end
endmodule : ldp_core_tb_top
`default_nettype wire
